// ### hdl/rsso_core.sv
// execute slice: rotates, set-to-ones, subtract with borrow and sleep
// assumes program memory offers one word with valid, taken when ready
// assumes one clock, a synchronous active high reset and synchronous inputs
`timescale 1ns/100ps
module rsso_core
  import rsso_pkg::*;
#(
  parameter int unsigned WDT_TICK = WDT_TICK_CYC,
  parameter logic [7:0] WDT_POST = WDT_POST_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // instruction stream
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  output logic insn_ready,
  // power and wake
  input wire logic wake_evt,
  output logic osc_run,
  output logic sleeping,
  // interrupt
  output logic irq
);
  // idle takes a word, exec writes back, sleep waits for a wake source
  typedef enum {ST_IDLE, ST_EXEC, ST_SLEEP} rsso_state_t;

  // sequencer state and the instruction under execution
  rsso_state_t state_r;
  rsso_insn_t cur_r;
  rsso_insn_t dec;
  // programmer visible registers
  rsso_flags_t flags_r;
  logic [1:0] ctrl_r;
  logic [7:0] work_r;
  logic [3:0] bank_r;
  logic [11:0] idx_r;
  logic power_down_flag_r;
  logic time_out_flag_r;
  // interrupt status, mask and this cycle's events
  logic [IRQ_W-1:0] irq_sts_r;
  logic [IRQ_W-1:0] irq_msk_r;
  logic [IRQ_W-1:0] irq_set;
  // watchdog prescaler and postscaler
  logic [15:0] tick_cnt_r;
  logic [7:0] post_cnt_r;
  logic wdt_tick;
  logic wdt_tout;
  // bus answer
  logic ack_r;
  logic [31:0] dat_r;
  // operand path
  logic [11:0] cur_addr_r;
  logic [11:0] eff_addr;
  logic [7:0] fdata;
  logic [7:0] res;
  rsso_flags_t flags_nxt;
  // sequencing strobes
  logic accept;
  logic do_sleep;
  logic wake;
  logic wr_file;
  logic wr_work;
  logic bus_wr;

  // resolve the 12-bit file address of an operand
  function automatic logic [11:0] eff_address(input rsso_insn_t d, input logic ext,
                                              input logic [3:0] bank, input logic [11:0] idx);
    logic [11:0] a;
    a = 12'h000;
    if (d.acc) begin
      a = {bank, d.faddr};
    end else if (ext && d.faddr <= IDX_LIMIT) begin
      a = idx + {4'h0, d.faddr};
    end else if (d.faddr < ACCESS_SPLIT) begin
      a = {ACCESS_LOW_BANK, d.faddr};
    end else begin
      a = {ACCESS_HIGH_BANK, d.faddr};
    end
    return a;
  endfunction

  // zero and negative flags of a result, shared by every flag-setting operation
  function automatic logic [1:0] zero_neg(input logic [7:0] r);
    return {(r == 8'h00), r[7]};
  endfunction

  // write strobe of a single-lane register; a lane-0 write to any other offset is ignored
  function automatic logic reg_write(input logic wr, input logic [7:0] adr,
                                     input logic lane0, input logic [7:0] off);
    return wr && (adr == off) && lane0;
  endfunction

  // issue side decode
  assign dec = rsso_decode(insn_word);
  assign insn_ready = (state_r == ST_IDLE);
  assign accept = insn_valid && insn_ready;
  assign do_sleep = accept && (dec.op == OP_SLEEP);
  assign eff_addr = eff_address(dec, ctrl_r[CTRL_EXT_BIT], bank_r, idx_r);
  assign sleeping = (state_r == ST_SLEEP);
  assign osc_run = !sleeping;
  assign wake = sleeping && (wake_evt || wdt_tout);

  // instruction sequencer: read operand, then execute and write back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (do_sleep) state_r <= ST_SLEEP;
          else if (accept && dec.op != OP_NONE) state_r <= ST_EXEC;
        end
        ST_EXEC: state_r <= ST_IDLE;
        ST_SLEEP: begin
          if (wake) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // latch the accepted instruction and its address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_r <= '0;
      cur_addr_r <= 12'h000;
    end else if (accept) begin
      cur_r <= dec;
      cur_addr_r <= eff_addr;
    end
  end

  // data path; flags stay as they are unless the operation updates them
  always_comb begin
    res = fdata;
    flags_nxt = flags_r;
    case (cur_r.op)
      OP_ROT_CARRY: begin
        res = {flags_r.c, fdata[7:1]};
        flags_nxt.c = fdata[0];
        {flags_nxt.z, flags_nxt.n} = zero_neg(res);
      end
      OP_ROT_PLAIN: begin
        res = {fdata[0], fdata[7:1]};
        {flags_nxt.z, flags_nxt.n} = zero_neg(res);
      end
      OP_SUB_BORROW: begin
        res = work_r - fdata - {7'h00, !flags_r.c};
        flags_nxt.c = ({1'b0, work_r} >= ({1'b0, fdata} + {8'h00, !flags_r.c}));
        flags_nxt.dc = ({1'b0, work_r[3:0]} >= ({1'b0, fdata[3:0]} + {4'h0, !flags_r.c}));
        flags_nxt.ov = (work_r[7] ^ fdata[7]) & (work_r[7] ^ res[7]);
        {flags_nxt.z, flags_nxt.n} = zero_neg(res);
      end
      OP_SET_ONES: begin
        res = ALL_ONES;
      end
      default: res = fdata;
    endcase
  end

  assign wr_file = (state_r == ST_EXEC) && (cur_r.op == OP_SET_ONES || cur_r.dest);
  assign wr_work = (state_r == ST_EXEC) && (cur_r.op != OP_SET_ONES) && !cur_r.dest;

  // operand store; its registered read lands the operand exactly in the exec cycle
  rsso_fmem #(
    .AW(12),
    .DW(8)
  ) u_fmem (
    .clk(clk),
    .rd_en(accept),
    .rd_addr(eff_addr),
    .rd_data(fdata),
    .we(wr_file),
    .wr_addr(cur_addr_r),
    .wr_data(res)
  );

  // working register; the core wins over a bus write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) work_r <= WORK_RST;
    else if (wr_work) work_r <= res;
    else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_WORK)) work_r <= wb_dat_i[7:0];
  end

  // arithmetic flags
  always_ff @(posedge clk) begin
    if (sys_rst) flags_r <= FLAGS_RST;
    else if (state_r == ST_EXEC) flags_r <= flags_nxt;
    else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_ALUF)) flags_r <= wb_dat_i[4:0];
  end

  // power down flag: set at reset, cleared by sleep; only a reset sets it again
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_down_flag_r <= POWER_DOWN_RST;
    end else if (do_sleep) begin
      power_down_flag_r <= 1'b0;
    end
  end

  // time out flag; software tells a watchdog wake from other wakes by it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      time_out_flag_r <= TIME_OUT_RST;
    end else if (do_sleep) begin
      time_out_flag_r <= 1'b1;
    end else if (sleeping && wdt_tout) begin
      time_out_flag_r <= 1'b0;
    end
  end

  // watchdog prescale divider; runs in sleep since it counts on clk, which keeps running
  assign wdt_tick = ctrl_r[CTRL_WDT_EN_BIT] && (tick_cnt_r == 16'(WDT_TICK - 1));
  always_ff @(posedge clk) begin
    if (sys_rst || !ctrl_r[CTRL_WDT_EN_BIT]) begin
      tick_cnt_r <= 16'h0000;
    end else if (do_sleep) begin
      tick_cnt_r <= 16'h0000;
    end else if (wdt_tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // watchdog postscaler; a pulse when it reaches its period
  assign wdt_tout = wdt_tick && (post_cnt_r == WDT_POST - 8'h01);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      post_cnt_r <= 8'h00;
    end else if (do_sleep) begin
      post_cnt_r <= 8'h00;
    end else if (wdt_tout) begin
      post_cnt_r <= 8'h00;
    end else if (wdt_tick) begin
      post_cnt_r <= post_cnt_r + 8'h01;
    end
  end

  // wishbone: one wait state, ack for one cycle, unmapped reads give zero
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
  always_ff @(posedge clk) begin
    if (sys_rst) ack_r <= 1'b0;
    else ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // read data captured at the request so it is steady with ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      case (wb_adr_i)
        REG_CTRL: dat_r <= {30'h0, ctrl_r};
        REG_WORK: dat_r <= {24'h0, work_r};
        REG_ALUF: dat_r <= {27'h0, flags_r};
        REG_BANK: dat_r <= {28'h0, bank_r};
        REG_IDX: dat_r <= {20'h0, idx_r};
        REG_PWR: dat_r <= {29'h0, sleeping, time_out_flag_r, power_down_flag_r};
        REG_WDT: dat_r <= {24'h0, post_cnt_r};
        REG_IRQ_STS: dat_r <= {28'h0, irq_sts_r};
        REG_IRQ_MSK: dat_r <= {28'h0, irq_msk_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end

  // control register: extended set enable and watchdog enable
  always_ff @(posedge clk) begin
    if (sys_rst) ctrl_r <= CTRL_RST;
    else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_CTRL)) ctrl_r <= wb_dat_i[1:0];
  end

  // bank select register
  always_ff @(posedge clk) begin
    if (sys_rst) bank_r <= BANK_RST;
    else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_BANK)) bank_r <= wb_dat_i[3:0];
  end

  // index base for literal offset addressing, byte lanes honoured
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_r <= IDX_RST;
    end else if (bus_wr && wb_adr_i == REG_IDX) begin
      if (wb_sel_i[0]) idx_r[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) idx_r[11:8] <= wb_dat_i[11:8];
    end
  end

  // interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SLEEP] = do_sleep;
    irq_set[IRQ_WAKE] = wake;
    irq_set[IRQ_BADOP] = accept && (dec.op == OP_NONE);
    irq_set[IRQ_WDT] = wdt_tout;
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_sts_r <= '0;
    end else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_IRQ_STS)) begin
      irq_sts_r <= (irq_sts_r & ~wb_dat_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_sts_r <= irq_sts_r | irq_set;
    end
  end

  // interrupt mask
  always_ff @(posedge clk) begin
    if (sys_rst) irq_msk_r <= '0;
    else if (reg_write(bus_wr, wb_adr_i, wb_sel_i[0], REG_IRQ_MSK)) begin
      irq_msk_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // level interrupt, high while an unmasked status bit is set
  assign irq = |(irq_sts_r & irq_msk_r);
endmodule // rsso_core

// ### hdl/rsso_fmem.sv
// general purpose file memory, one write and one registered read port
// assumes a single clock; read data appear the cycle after rd_en
`timescale 1ns/100ps
module rsso_fmem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write side
  always_ff @(posedge clk) begin
    if (we) mem[wr_addr] <= wr_data;
  end

  // registered read; contents are undefined until written
  always_ff @(posedge clk) begin
    if (rd_en) rd_data <= mem[rd_addr];
  end
endmodule // rsso_fmem

// ### hdl/rsso_pkg.sv
// package for the rotate/subtract/sleep execute slice
// assumes a 100 MHz core clock and a classic wishbone register port
// Contract
// - plain rotate right wraps bit0 into bit7
// - bank bit 0 selects access bank
// - bank bit 1 uses bank select register
// - extended set, f<=0x5f uses indexed offset
// - subtract: w minus f minus borrow
// - dest 0 to w, 1 to file
// - sleep clears power down flag
// - sleep sets time out flag
// - sleep clears watchdog and postscaler
// - sleep halts with oscillator stopped until wake
// - watchdog wake clears time out flag
package rsso_pkg;
  // clock and watchdog timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WDT_TICK_NS = 4000;
  localparam int unsigned WDT_TICK_CYC = (WDT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WDT_POST_DEF = 8'h80;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WORK = 8'h04;
  localparam logic [7:0] REG_ALUF = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_IDX = 8'h10;
  localparam logic [7:0] REG_PWR = 8'h14;
  localparam logic [7:0] REG_WDT = 8'h18;
  localparam logic [7:0] REG_IRQ_STS = 8'h1c;
  localparam logic [7:0] REG_IRQ_MSK = 8'h20;
  // control bits and reset values
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned CTRL_WDT_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] IDX_RST = 12'h000;
  localparam logic POWER_DOWN_RST = 1'b1;
  localparam logic TIME_OUT_RST = 1'b1;
  // interrupt event bits
  localparam int unsigned IRQ_SLEEP = 0;
  localparam int unsigned IRQ_WAKE = 1;
  localparam int unsigned IRQ_BADOP = 2;
  localparam int unsigned IRQ_WDT = 3;
  localparam int unsigned IRQ_W = 4;
  // instruction encodings
  localparam logic [5:0] OPC_ROT_CARRY = 6'h0c;
  localparam logic [5:0] OPC_ROT_PLAIN = 6'h10;
  localparam logic [5:0] OPC_SUB_BORROW = 6'h15;
  localparam logic [6:0] OPC_SET_ONES = 7'h34;
  localparam logic [15:0] INSN_SLEEP = 16'h0003;
  // file addressing
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [7:0] ALL_ONES = 8'hff;

  typedef enum logic [2:0] {
    OP_NONE, OP_ROT_CARRY, OP_ROT_PLAIN, OP_SUB_BORROW, OP_SET_ONES, OP_SLEEP
  } rsso_op_t;

  typedef struct packed {
    rsso_op_t op;
    logic dest;
    logic acc;
    logic [7:0] faddr;
  } rsso_insn_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } rsso_flags_t;

  localparam rsso_flags_t FLAGS_RST = 5'h00;

  // split an instruction word into operation and operand fields
  function automatic rsso_insn_t rsso_decode(input logic [15:0] w);
    rsso_insn_t d;
    d.dest = w[9];
    d.acc = w[8];
    d.faddr = w[7:0];
    if (w == INSN_SLEEP) d.op = OP_SLEEP;
    else if (w[15:10] == OPC_ROT_CARRY) d.op = OP_ROT_CARRY;
    else if (w[15:10] == OPC_ROT_PLAIN) d.op = OP_ROT_PLAIN;
    else if (w[15:10] == OPC_SUB_BORROW) d.op = OP_SUB_BORROW;
    else if (w[15:9] == OPC_SET_ONES) d.op = OP_SET_ONES;
    else d.op = OP_NONE;
    return d;
  endfunction
endpackage

// ### testbench/rsso_core_properties.sv
// port checker for the execute slice: bus answers, instruction handshake, sleep
// assumes it is bound to rsso_core and sees only its ports
`timescale 1ns/100ps
module rsso_core_properties
  import rsso_pkg::*;
#(
  parameter int unsigned WDT_TICK = WDT_TICK_CYC,
  parameter logic [7:0] WDT_POST = WDT_POST_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // instructions and power
  input wire logic insn_valid,
  input wire logic [15:0] insn_word,
  input wire logic insn_ready,
  input wire logic wake_evt,
  input wire logic osc_run,
  input wire logic sleeping
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req, take, known, slp;
  // request and decode helpers
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign take = insn_valid && insn_ready;
  assign slp = insn_word == INSN_SLEEP;
  assign known = insn_word[15:10] inside {OPC_ROT_CARRY, OPC_ROT_PLAIN, OPC_SUB_BORROW}
    || insn_word[15:9] == OPC_SET_ONES;
  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h24 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_exec_one_cycle: assert property (take && known |=> !insn_ready ##1 insn_ready)
    else $error("execute not one cycle");
  a_unknown_ignored: assert property (take && !known && !slp |=> insn_ready)
    else $error("unknown word stalled");
  a_sleep_entry: assert property (take && slp |=> sleeping && !osc_run)
    else $error("sleep not entered");
  a_osc_stopped: assert property (sleeping |-> !osc_run && !insn_ready)
    else $error("oscillator runs while asleep");
  a_wake_exit: assert property (sleeping && wake_evt |=> !sleeping)
    else $error("wake ignored");
  a_sleep_flags: assert property (req && !wb_we_i && wb_adr_i == REG_PWR && sleeping
    |=> wb_dat_o[1:0] == 2'b10)
    else $error("power flags wrong in sleep");
endmodule // rsso_core_properties

// ### testbench/rsso_core_tb.sv
// self-checking bench for the execute slice
// assumes rsso_core with a shortened watchdog and the program memory model
`timescale 1ns/100ps
module rsso_core_tb import rsso_pkg::*;;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, insn_valid, insn_ready;
  logic wake_evt, osc_run, sleeping, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] insn_word;
  int n_errors, tests_run;
  // watchdog shortened to 64 cycles so sleep wake fits the run
  rsso_core #(.WDT_TICK(16), .WDT_POST(8'h04)) dut (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .insn_valid(insn_valid), .insn_word(insn_word), .insn_ready(insn_ready),
    .wake_evt(wake_evt), .osc_run(osc_run), .sleeping(sleeping), .irq(irq));
  rsso_prog_mem pm (.clk(clk), .insn_ready(insn_ready), .insn_valid(insn_valid),
    .insn_word(insn_word));
  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // no limit here: only the hang guard may end a wait for ack
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  // run one word and wait for the core to be ready again
  task automatic ex(input logic [15:0] w);
    int n;
    n = 0;
    pm.offer(w, 0);
    do begin
      @(posedge clk);
      n++;
    end while (insn_ready !== 1'b1 && n < 50);
    if (insn_ready !== 1'b1) n_errors++;
  endtask
  task automatic t_reset();
    wb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, REG_PWR, 32'h0);
    chk(rd, 32'h3);
    wb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
  endtask
  // file 0x010 gets 0x02, bank 2 copy stays all ones
  task automatic t_bank();
    wb(1'b1, REG_CTRL, 32'h0);
    wb(1'b1, REG_ALUF, 32'h1f);
    ex({OPC_SET_ONES, 1'b0, 8'h10});
    wb(1'b0, REG_ALUF, 32'h0);
    chk(rd, 32'h1f);
    wb(1'b1, REG_ALUF, 32'h01);
    wb(1'b1, REG_WORK, 32'h01);
    ex({OPC_SUB_BORROW, 2'b10, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'h01);
    wb(1'b0, REG_ALUF, 32'h0);
    chk(rd, 32'h00);
    wb(1'b1, REG_BANK, 32'h2);
    ex({OPC_SET_ONES, 1'b1, 8'h10});
    ex({OPC_ROT_PLAIN, 2'b00, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'h01);
    ex({OPC_ROT_PLAIN, 2'b01, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'hff);
  endtask
  task automatic t_arith();
    wb(1'b1, REG_ALUF, 32'h01);
    ex({OPC_ROT_CARRY, 2'b00, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'h81);
    wb(1'b0, REG_ALUF, 32'h0);
    chk(rd, 32'h10);
    wb(1'b1, REG_ALUF, 32'h00);
    wb(1'b1, REG_WORK, 32'h05);
    ex({OPC_SUB_BORROW, 2'b00, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'h02);
    wb(1'b0, REG_ALUF, 32'h0);
    chk(rd, 32'h03);
    ex({OPC_ROT_PLAIN, 2'b10, 8'h10});
    ex({OPC_ROT_PLAIN, 2'b10, 8'h10});
    ex({OPC_ROT_PLAIN, 2'b00, 8'h10});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'h40);
  endtask
  // boundary offset 0x5f from base 0x1b1 lands on 0x210
  task automatic t_index();
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b1, REG_IDX, 32'h1b1);
    ex({OPC_ROT_PLAIN, 2'b00, 8'h5f});
    wb(1'b0, REG_WORK, 32'h0);
    chk(rd, 32'hff);
    wb(1'b1, REG_CTRL, 32'h0);
  endtask
  task automatic t_irq();
    wb(1'b1, REG_IRQ_MSK, 32'h4);
    ex(16'hffff);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    wb(1'b0, REG_IRQ_STS, 32'h0);
    chk(rd, 32'h4);
    wb(1'b1, REG_IRQ_MSK, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
    wb(1'b1, REG_IRQ_MSK, 32'h4);
    wb(1'b1, REG_IRQ_STS, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 32'h0);
  endtask
  task automatic t_sleep();
    int n;
    n = 0;
    wb(1'b1, REG_CTRL, 32'h2);
    // let the postscaler advance so that the clear by sleep is visible
    repeat (40) @(posedge clk);
    wb(1'b0, REG_WDT, 32'h0);
    chk(rd, 32'h2);
    pm.offer(INSN_SLEEP, 2);
    @(posedge clk);
    chk({sleeping, osc_run, insn_ready}, 32'h4);
    wb(1'b0, REG_WDT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, REG_PWR, 32'h0);
    chk(rd, 32'h6);
    @(posedge clk);
    wake_evt <= 1'b1;
    @(posedge clk);
    wake_evt <= 1'b0;
    @(posedge clk);
    chk(sleeping, 32'h0);
    wb(1'b0, REG_PWR, 32'h0);
    chk(rd, 32'h2);
    pm.offer(INSN_SLEEP, 0);
    repeat (40) @(posedge clk);
    chk(sleeping, 32'h1);
    do begin
      @(posedge clk);
      n++;
    end while (sleeping !== 1'b0 && n < 100);
    if (sleeping !== 1'b0) n_errors++;
    wb(1'b0, REG_PWR, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic end_sim();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wake_evt} = 5'h10;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_bank();
    t_arith();
    t_index();
    t_irq();
    t_sleep();
    end_sim();
  end
  // hang guard, well beyond the roughly 300 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule // rsso_core_tb
bind rsso_core rsso_core_properties #(.WDT_TICK(WDT_TICK), .WDT_POST(WDT_POST)) u_props (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .insn_valid(insn_valid),
  .insn_word(insn_word), .insn_ready(insn_ready), .wake_evt(wake_evt), .osc_run(osc_run),
  .sleeping(sleeping));

// ### testbench/rsso_prog_mem.sv
// program memory model offering instruction words to the core
// assumes the core takes a word at an edge where valid and ready are high
`timescale 1ns/100ps
module rsso_prog_mem (
  // clock
  input wire logic clk,
  // instruction stream
  input wire logic insn_ready,
  output logic insn_valid,
  output logic [15:0] insn_word
);
  // idle at time zero
  initial begin
    insn_valid = 1'b0;
    insn_word = 16'h5a5a;
  end
  // offer a word after gap idle cycles and hold it until taken
  task automatic offer(input logic [15:0] w, input int gap);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clk);
    insn_valid <= 1'b1;
    insn_word <= w;
    do begin
      @(posedge clk);
      n++;
    end while (insn_ready !== 1'b1 && n < 500);
    insn_valid <= 1'b0;
    insn_word <= ~w; // a released bus never shows a stale word
  endtask
endmodule // rsso_prog_mem
